// *** shared/awc_defs.vh ***
// Purpose: constants for the analog window comparator block
// Assumes: holding register addresses are word indices
// Notes: definitions only
`ifndef AWC_DEFS_VH
`define AWC_DEFS_VH
`define AWC_ADDR_REF_SEL 16'h010e
`define AWC_ADDR_STATUS 16'h01f4
`define AWC_ADDR_THR_LOW 16'h01f5
`define AWC_ADDR_THR_MID 16'h01f6
`define AWC_ADDR_THR_HIGH 16'h01f7
`define AWC_ADDR_HYST 16'h01f8
`define AWC_ADDR_STATUS_COPY 16'h0229
`define AWC_HYST_MAX 16'h001d
`define AWC_STATUS_BAD_HYST 16'hff00
`define AWC_RST_REF_SEL 16'h0000
`define AWC_RST_THR_LOW 16'h0400
`define AWC_RST_THR_MID 16'h0800
`define AWC_RST_THR_HIGH 16'h0c00
`define AWC_RST_HYST 16'h0008
`define AWC_FAULT_BIT_BASE 8
`endif

// *** hw/awc_window_comparator.v ***
// Purpose: eight-channel window comparator with status register over holding registers
// Assumes: adc codes and register strobes synchronous to clk_i
// Notes: answers one cycle after each strobe, from flops
`timescale 1ns/1ps
`include "awc_defs.vh"
module awc_window_comparator #(
    parameter NCH = 8,
    parameter CODE_W = 12,
    parameter LEGACY_LAYOUT = 0
) (
    // clock and reset
    input wire clk_i,
    input wire rstn_i,
    // converter codes, channel k at bits k*CODE_W
    input wire [NCH*CODE_W-1:0] adc_code_i,
    // holding register access
    input wire [15:0] reg_addr_i,
    input wire reg_wr_i,
    input wire [15:0] reg_wdata_i,
    input wire reg_rd_i,
    output reg [15:0] reg_rdata_o,
    output reg reg_ack_o,
    output reg reg_err_o,
    // reference selection to the analog front end
    output reg [15:0] ref_select_o,
    // live status
    output reg [15:0] status_o
);
    // threshold set and hysteresis, one copy for all channels
    reg [15:0] thr_low;
    reg [15:0] thr_mid;
    reg [15:0] thr_high;
    reg [15:0] hyst;
    // comparator results per channel
    wire [NCH-1:0] sig_bits;
    wire [NCH-1:0] flt_bits;
    // status and register read path
    reg [15:0] next_status;
    reg [15:0] next_rdata;
    reg next_hit;
    wire hyst_bad;
    wire any_stb;
    wire ro_addr;
    wire ro_write;
    wire refused;
    integer i;

    // 17-bit sums avoid wrap at the top end; below zero the differences wrap and the under flags cover it
    wire [16:0] low_lo = {1'b0, thr_low} - {1'b0, hyst};
    wire [16:0] low_hi = {1'b0, thr_low} + {1'b0, hyst};
    wire [16:0] mid_lo = {1'b0, thr_mid} - {1'b0, hyst};
    wire [16:0] mid_hi = {1'b0, thr_mid} + {1'b0, hyst};
    wire [16:0] high_lo = {1'b0, thr_high} - {1'b0, hyst};
    wire [16:0] high_hi = {1'b0, thr_high} + {1'b0, hyst};
    wire low_under = thr_low < hyst;
    wire mid_under = thr_mid < hyst;
    wire high_under = thr_high < hyst;

    assign hyst_bad = hyst > `AWC_HYST_MAX;

    // thresholds and hysteresis shared by all channels
    genvar g;
    generate
        for (g = 0; g < NCH; g = g + 1) begin : gch
            wire [16:0] code;
            wire set_flt;
            wire clr_flt;
            wire set_sig;
            wire clr_sig;
            reg flt_q;
            reg sig_q;
            reg next_flt;
            reg next_sig;
            assign code = {{(17-CODE_W){1'b0}}, adc_code_i[g*CODE_W +: CODE_W]};
            // a bound below zero can never be crossed, so its test stays false
            assign set_flt = (!low_under && code < low_lo) || code > high_hi;
            assign clr_flt = code > low_hi && !high_under && code < high_lo;
            assign set_sig = code > mid_hi;
            assign clr_sig = !mid_under && code < mid_lo;
            // inside a band neither test holds and the old bit stays
            always @* begin
                next_flt = flt_q;
                next_sig = sig_q;
                if (set_flt) begin
                    next_flt = 1'b1;
                end else if (clr_flt) begin
                    next_flt = 1'b0;
                end
                if (set_sig) begin
                    next_sig = 1'b1;
                end else if (clr_sig) begin
                    next_sig = 1'b0;
                end
            end
            always @(posedge clk_i or negedge rstn_i) begin
                if (!rstn_i) begin
                    flt_q <= 1'b0;
                    sig_q <= 1'b0;
                end else begin
                    flt_q <= next_flt;
                    sig_q <= next_sig;
                end
            end
            assign flt_bits[g] = flt_q;
            assign sig_bits[g] = sig_q;
        end
    endgenerate

    always @* begin
        next_status = 16'h0000;
        if (hyst_bad) begin
            next_status = `AWC_STATUS_BAD_HYST;
        end else if (LEGACY_LAYOUT != 0) begin
            for (i = 0; i < NCH; i = i + 1) begin
                next_status[2*i] = sig_bits[i];
                next_status[2*i+1] = flt_bits[i];
            end
        end else begin
            for (i = 0; i < NCH; i = i + 1) begin
                next_status[i] = sig_bits[i];
                next_status[`AWC_FAULT_BIT_BASE+i] = flt_bits[i];
            end
        end
    end

    // unmapped words read as zero and are refused
    always @* begin
        next_hit = 1'b1;
        next_rdata = 16'h0000;
        case (reg_addr_i)
            `AWC_ADDR_REF_SEL: begin
                next_rdata = ref_select_o;
            end
            `AWC_ADDR_STATUS: begin
                next_rdata = status_o;
            end
            `AWC_ADDR_STATUS_COPY: begin
                next_rdata = status_o;
            end
            `AWC_ADDR_THR_LOW: begin
                next_rdata = thr_low;
            end
            `AWC_ADDR_THR_MID: begin
                next_rdata = thr_mid;
            end
            `AWC_ADDR_THR_HIGH: begin
                next_rdata = thr_high;
            end
            `AWC_ADDR_HYST: begin
                next_rdata = hyst;
            end
            default: begin
                next_hit = 1'b0;
            end
        endcase
    end

    // status and its mirror are read-only, writes there are refused
    assign any_stb = reg_wr_i | reg_rd_i;
    assign ro_addr = (reg_addr_i == `AWC_ADDR_STATUS) | (reg_addr_i == `AWC_ADDR_STATUS_COPY);
    assign ro_write = reg_wr_i & ro_addr;
    assign refused = any_stb & (~next_hit | ro_write);

    // status register, refreshed every cycle
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            status_o <= 16'h0000;
        end else begin
            status_o <= next_status;
        end
    end

    // configuration registers and bus answer
    always @(posedge clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
            thr_low <= `AWC_RST_THR_LOW;
            thr_mid <= `AWC_RST_THR_MID;
            thr_high <= `AWC_RST_THR_HIGH;
            hyst <= `AWC_RST_HYST;
            ref_select_o <= `AWC_RST_REF_SEL;
            reg_rdata_o <= 16'h0000;
            reg_ack_o <= 1'b0;
            reg_err_o <= 1'b0;
        end else begin
            reg_ack_o <= any_stb;
            reg_err_o <= refused;
            if (reg_rd_i) begin
                reg_rdata_o <= next_rdata;
            end
            if (reg_wr_i) begin
                case (reg_addr_i)
                    `AWC_ADDR_REF_SEL: begin
                        ref_select_o <= reg_wdata_i;
                    end
                    `AWC_ADDR_THR_LOW: begin
                        thr_low <= reg_wdata_i;
                    end
                    `AWC_ADDR_THR_MID: begin
                        thr_mid <= reg_wdata_i;
                    end
                    `AWC_ADDR_THR_HIGH: begin
                        thr_high <= reg_wdata_i;
                    end
                    `AWC_ADDR_HYST: begin
                        hyst <= reg_wdata_i;
                    end
                    default: begin
                    end
                endcase
            end
        end
    end
endmodule

// *** testbench/awc_master_model.sv ***
// Purpose: register master model for the comparator bench
// Assumes: strobes launched at falling edges
// Notes: released address and data lines show the inverted last value so stale data cannot pass; both strobes drop to zero
`timescale 1ns/1ps
module awc_master_model (
    input wire clk_i, reg_ack_i, reg_err_i,
    input wire [15:0] reg_rdata_i,
    output logic reg_wr_o = 0, reg_rd_o = 0,
    output logic [15:0] reg_addr_o = 0, reg_wdata_o = 0
);
    task xfer(input logic w, input logic [15:0] a, d, output logic [15:0] q, output logic [1:0] r);
        @(negedge clk_i);
        {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {w, !w, a, d};
        @(negedge clk_i);
        {reg_wr_o, reg_rd_o, reg_addr_o, reg_wdata_o} = {2'b00, ~a, ~d};
        {q, r} = {reg_rdata_i, reg_ack_i, reg_err_i};
    endtask
endmodule

// *** testbench/awc_monitor.sv ***
// Purpose: port-level checker for the comparator
// Assumes: one clock domain
// Notes: bound to every comparator instance
`timescale 1ns/1ps
`include "awc_defs.vh"
module awc_monitor #(parameter NCH = 8, parameter CODE_W = 12) (
    input wire clk_i, rstn_i, reg_wr_i, reg_rd_i, reg_ack_o, reg_err_o,
    input wire [NCH*CODE_W-1:0] adc_code_i,
    input wire [15:0] reg_addr_i, reg_wdata_i, reg_rdata_o, status_o
);
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (!rstn_i);
    wire stb = reg_wr_i || reg_rd_i;
    wire hwr = reg_wr_i && reg_addr_i == `AWC_ADDR_HYST;
    ack_follow_a: assert property (stb |=> reg_ack_o) else $error("ack missing");
    ack_idle_a: assert property (!stb |=> !reg_ack_o) else $error("stray ack");
    ro_refuse_a: assert property (reg_wr_i && (reg_addr_i == `AWC_ADDR_STATUS ||
        reg_addr_i == `AWC_ADDR_STATUS_COPY) |=> reg_err_o) else $error("status write taken");
    map_ok_a: assert property (reg_rd_i && reg_addr_i >= `AWC_ADDR_THR_LOW &&
        reg_addr_i <= `AWC_ADDR_HYST |=> !reg_err_o) else $error("threshold read refused");
    mirror_read_a: assert property (reg_rd_i && reg_addr_i == `AWC_ADDR_STATUS_COPY
        |=> reg_rdata_o == $past(status_o)) else $error("mirror differs");
    status_read_a: assert property (reg_rd_i && reg_addr_i == `AWC_ADDR_STATUS
        |=> reg_rdata_o == $past(status_o)) else $error("status read differs");
    hyst_bad_a: assert property (hwr && reg_wdata_i > `AWC_HYST_MAX ##1 !hwr [*2]
        |=> status_o == `AWC_STATUS_BAD_HYST) else $error("bad hysteresis not flagged");
    hold_still_a: assert property (($stable(adc_code_i) && !reg_wr_i) [*3]
        |=> $stable(status_o)) else $error("status moved without cause");
endmodule
bind awc_window_comparator awc_monitor #(.NCH(NCH), .CODE_W(CODE_W)) awc_monitor_i (.clk_i(clk_i),
    .rstn_i(rstn_i), .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_ack_o(reg_ack_o), .reg_err_o(reg_err_o),
    .adc_code_i(adc_code_i), .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i), .reg_rdata_o(reg_rdata_o),
    .status_o(status_o));

// *** testbench/testbench.sv ***
// Purpose: self-checking bench for the comparator
// Assumes: thresholds low/mid/high/hyst written as 0x400/0x800/0xc00/8
// Notes: rows are ch7 code, ch0 code, status; other channels sit healthy
`timescale 1ns/1ps
`include "awc_defs.vh"
module testbench;
    logic clk_i = 0, rstn_i = 0;
    logic [95:0] adc = {8{12'h600}};
    wire [15:0] ad, wd, rdd, ref_o, st, st_leg;
    wire wr, rd, ack, err;
    logic [15:0] q;
    logic [1:0] r;
    logic [15:0] thr [4] = '{16'h0400, 16'h0800, 16'h0c00, 16'h0008};
    logic [39:0] rows [11] = '{40'h60_0600_0000, 40'h60_0900_0001, 40'h60_0805_0001, 40'h60_07f0_0000,
        40'h60_0300_0100, 40'h60_03fa_0100, 40'h60_0409_0000, 40'h60_0d00_0101, 40'h60_0c05_0101,
        40'h60_0bf0_0001, 40'hd0_0bf0_8081};
    int num_errors = 0, n_compared = 0;
    initial forever #20 clk_i = ~clk_i;
    awc_window_comparator awc_window_comparator_i (.clk_i(clk_i), .rstn_i(rstn_i), .adc_code_i(adc),
        .reg_addr_i(ad), .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rd_i(rd), .reg_rdata_o(rdd),
        .reg_ack_o(ack), .reg_err_o(err), .ref_select_o(ref_o), .status_o(st));
    awc_master_model awc_master_model_i (.clk_i(clk_i), .reg_ack_i(ack), .reg_err_i(err), .reg_rdata_i(rdd),
        .reg_wr_o(wr), .reg_rd_o(rd), .reg_addr_o(ad), .reg_wdata_o(wd));
    // second copy in the paired layout, fed the same codes and bus
    awc_window_comparator #(.LEGACY_LAYOUT(1)) awc_window_comparator_legacy_i (.clk_i(clk_i), .rstn_i(rstn_i),
        .adc_code_i(adc), .reg_addr_i(ad), .reg_wr_i(wr), .reg_wdata_i(wd), .reg_rd_i(rd), .reg_rdata_o(),
        .reg_ack_o(), .reg_err_o(), .ref_select_o(), .status_o(st_leg));
    task chk(input string n, input logic [15:0] e, g);
        n_compared++;
        if (g !== e) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, g);
        end
    endtask
    task rw(input logic w, input logic [15:0] a, d, input logic ee);
        awc_master_model_i.xfer(w, a, d, q, r);
        chk("response", {14'h0, 1'b1, ee}, {14'h0, r});
    endtask
    // bad hysteresis reads the same word in either layout
    function automatic logic [15:0] legacy_of(input logic [15:0] s);
        logic [15:0] v;
        v = s;
        if (s != `AWC_STATUS_BAD_HYST) begin
            for (int k = 0; k < 8; k++) begin
                v[2*k] = s[k];
                v[2*k+1] = s[8+k];
            end
        end
        return v;
    endfunction
    task settle_chk(input string n, input logic [15:0] e);
        repeat (3) @(negedge clk_i);
        chk(n, e, st);
        chk({n, " legacy"}, legacy_of(e), st_leg);
    endtask
    task tally_and_finish;
        $display("errors %0d compared %0d", num_errors, n_compared);
        if (num_errors == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    initial begin
        #20000;
        num_errors++;
        tally_and_finish;
    end
    initial begin
        repeat (6) @(negedge clk_i);
        rstn_i = 1;
        rw(0, `AWC_ADDR_HYST, 0, 0);
        chk("hyst reset", 16'h0008, q);
        rw(1, `AWC_ADDR_REF_SEL, 16'h0001, 0);
        chk("ref select", 16'h0001, ref_o);
        rw(1, `AWC_ADDR_REF_SEL, 16'h0000, 0);
        chk("ref zero", 16'h0000, ref_o);
        for (int i = 0; i < 4; i++) rw(1, 16'(`AWC_ADDR_THR_LOW + i), thr[i], 0);
        foreach (rows[i]) begin
            adc = {rows[i][39:28], {6{12'h600}}, rows[i][27:16]};
            settle_chk("status", rows[i][15:0]);
        end
        rw(0, `AWC_ADDR_STATUS_COPY, 0, 0);
        chk("mirror", 16'h8081, q);
        rw(0, `AWC_ADDR_STATUS, 0, 0);
        chk("status read", 16'h8081, q);
        rw(1, `AWC_ADDR_STATUS, 0, 1);
        rw(0, 16'h0300, 0, 1);
        chk("unmapped", 16'h0000, q);
        rw(1, `AWC_ADDR_HYST, 16'h001e, 0);
        settle_chk("bad hyst", `AWC_STATUS_BAD_HYST);
        rw(1, `AWC_ADDR_HYST, 16'h001d, 0);
        settle_chk("hyst 29", 16'h8081);
        rw(1, `AWC_ADDR_THR_MID, 16'h0e00, 0);
        settle_chk("mid moved", 16'h8000);
        // mid-run reset must bring back register defaults and restart the bits
        rw(1, `AWC_ADDR_REF_SEL, 16'h0001, 0);
        @(negedge clk_i);
        rstn_i = 0;
        @(negedge clk_i);
        chk("status in reset", 16'h0000, st);
        chk("ref in reset", `AWC_RST_REF_SEL, ref_o);
        rstn_i = 1;
        rw(0, `AWC_ADDR_THR_MID, 0, 0);
        chk("mid after reset", `AWC_RST_THR_MID, q);
        settle_chk("after reset", 16'h8081);
        tally_and_finish;
    end
endmodule
